//--- rtl/tcpwm_top.sv
// Notes on behaviour
// - each channel counts with a 16-bit counter against a software period.
// - capture event, from a pin, copies the count into a capture register.
// - count equal to period either halts counter or reloads and continues.
// - counter compared with software compare value gives the PWM duty.
// - true and complementary outputs separated by programmable dead band.
// - kill input forces both outputs to preset levels without software.
// - eight independent channels, each with own counter and registers.
`timescale 1ns/1ps
module tcpwm_top
  import tcpwm_pkg::*;
#(
  parameter int unsigned NCH = tcpwm_pkg::CHANNELS
) (
  input  wire logic                          CLK_I,
  input  wire logic                          RST_I,
  input  wire logic                          PSEL_I,
  input  wire logic                          PENABLE_I,
  input  wire logic                          PWRITE_I,
  input  wire logic [tcpwm_pkg::ADDR_W-1:0]  PADDR_I,
  input  wire logic [tcpwm_pkg::DATA_W-1:0]  PWDATA_I,
  output logic      [tcpwm_pkg::DATA_W-1:0]  PRDATA_O,
  output logic                               PREADY_O,
  output logic                               PSLVERR_O,
  input  wire logic [NCH-1:0]                CAPTURE_I,
  input  wire logic [NCH-1:0]                KILL_I,
  output logic      [NCH-1:0]                PWM_O,
  output logic      [NCH-1:0]                PWM_N_O
);

  logic [2*NCH-1:0]  sync_q;
  logic [NCH-1:0]    cap_s;
  logic [NCH-1:0]    kill_s;
  logic [DIV_W-1:0]  div;
  logic              access;
  logic              wr_en;
  logic [2:0]        ch_sel;
  logic [2:0]        reg_sel;
  logic              addr_ok;
  logic [DATA_W-1:0] next_rdata;

  logic [CTRL_W-1:0] ctrl_a  [NCH];
  logic [CNT_W-1:0]  per_a   [NCH];
  logic [CNT_W-1:0]  cmp_a   [NCH];
  logic [DEAD_W-1:0] dead_a  [NCH];
  logic [CNT_W-1:0]  cnt_a   [NCH];
  logic [CNT_W-1:0]  capt_a  [NCH];
  logic [2:0]        stat_a  [NCH];
  logic [NCH-1:0]    pwm_v;
  logic [NCH-1:0]    pwm_n_v;

  // pin inputs cross into the clock domain first
  tcpwm_sync #(
    .W (2*NCH)
  ) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({KILL_I, CAPTURE_I}),
    .q_o   (sync_q)
  );

  assign kill_s = sync_q[2*NCH-1:NCH];
  assign cap_s  = sync_q[NCH-1:0];

  // free-running divider shared by all prescalers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // apb decode
  assign access  = PSEL_I && PENABLE_I;
  assign ch_sel  = PADDR_I[CH_LSB +: 3];
  assign reg_sel = PADDR_I[REG_LSB +: 3];
  assign addr_ok = (PADDR_I[1:0] == 2'b00) && (reg_sel <= OFF_STATUS)
                   && (32'(ch_sel) < NCH);
  // write lands only on the edge that samples pready high
  assign wr_en   = access && PREADY_O && PWRITE_I && addr_ok;

  always_comb begin
    next_rdata = '0;
    if (addr_ok) begin
      case (reg_sel)
        OFF_CTRL:    next_rdata = 32'(ctrl_a[ch_sel]);
        OFF_PERIOD:  next_rdata = 32'(per_a[ch_sel]);
        OFF_COMPARE: next_rdata = 32'(cmp_a[ch_sel]);
        OFF_DEAD:    next_rdata = 32'(dead_a[ch_sel]);
        OFF_COUNT:   next_rdata = 32'(cnt_a[ch_sel]);
        OFF_CAPTURE: next_rdata = 32'(capt_a[ch_sel]);
        OFF_STATUS:  next_rdata = 32'(stat_a[ch_sel]);
        default:     next_rdata = '0;
      endcase
    end
  end

  // one wait state keeps every bus output on a flop
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= '0;
    end else begin
      PREADY_O  <= access && !PREADY_O;
      PSLVERR_O <= access && !PREADY_O && !addr_ok;
      if (access && !PREADY_O && !PWRITE_I) begin
        PRDATA_O <= next_rdata;
      end else begin
        PRDATA_O <= '0;
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0]  period;
    logic [CNT_W-1:0]  compare;
    logic [DEAD_W-1:0] dead;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  capt;
    logic              done;
    logic              capt_flag;
    logic              cap_prev;
    logic              raw_prev;
    logic [DEAD_W-1:0] dt_cnt;
    logic              pwm;
    logic              pwm_n;
    logic              hit;
    logic              run;
    logic              tick;
    logic              raw;
    logic              cap_evt;
    logic              killed;
    logic [DIV_W-1:0]  mask;

    assign hit     = wr_en && (ch_sel == 3'(g));
    assign run     = ctrl[CTRL_EN] && !done;
    assign mask    = DIV_W'((9'd1 << ctrl[CTRL_PS_LSB +: 3]) - 9'd1);
    assign tick    = (div & mask) == '0;
    assign cap_evt = cap_s[g] && !cap_prev && ctrl[CTRL_CAP_EN];
    assign killed  = kill_s[g] && ctrl[CTRL_KILL_EN];
    assign raw     = count < compare;

    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        ctrl    <= RST_CTRL;
        period  <= RST_PERIOD;
        compare <= RST_COMPARE;
        dead    <= RST_DEAD;
      end else if (hit) begin
        case (reg_sel)
          OFF_CTRL:    ctrl    <= PWDATA_I[CTRL_W-1:0];
          OFF_PERIOD:  period  <= PWDATA_I[CNT_W-1:0];
          OFF_COMPARE: compare <= PWDATA_I[CNT_W-1:0];
          OFF_DEAD:    dead    <= PWDATA_I[DEAD_W-1:0];
          default:     ctrl    <= ctrl;
        endcase
      end
    end

    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        count <= '0;
        done  <= 1'b0;
      end else if (hit && reg_sel == OFF_COUNT) begin
        count <= PWDATA_I[CNT_W-1:0];
      end else if (hit && reg_sel == OFF_CTRL) begin
        // any control write re-arms a halted one-shot
        done  <= 1'b0;
        if (done) begin
          count <= '0;
        end
      end else if (run && tick) begin
        if (count == period) begin
          if (ctrl[CTRL_ONESHOT]) begin
            done <= 1'b1;
          end else begin
            count <= '0;
          end
        end else begin
          count <= count + 1'b1;
        end
      end
    end

    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        capt      <= '0;
        cap_prev  <= 1'b0;
        capt_flag <= 1'b0;
      end else begin
        cap_prev <= cap_s[g];
        if (cap_evt) begin
          capt <= count;
        end
        // set wins over a clear in the same cycle
        if (cap_evt) begin
          capt_flag <= 1'b1;
        end else if (hit && reg_sel == OFF_STATUS
                     && PWDATA_I[STAT_CAPT]) begin
          capt_flag <= 1'b0;
        end
      end
    end

    // both off while dead counter runs
    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        raw_prev <= 1'b0;
        dt_cnt   <= '0;
      end else begin
        raw_prev <= raw;
        if (raw != raw_prev) begin
          dt_cnt <= dead;
        end else if (dt_cnt != '0) begin
          dt_cnt <= dt_cnt - 1'b1;
        end
      end
    end

    always_ff @(posedge CLK_I) begin
      if (RST_I) begin
        pwm   <= 1'b0;
        pwm_n <= 1'b0;
      end else if (killed) begin
        pwm   <= ctrl[CTRL_KILL_T];
        pwm_n <= ctrl[CTRL_KILL_C];
      end else if (!ctrl[CTRL_EN]) begin
        pwm   <= 1'b0;
        pwm_n <= 1'b0;
      end else begin
        // a toggle never switches both at once
        pwm   <= raw && (raw == raw_prev) && (dt_cnt == '0);
        pwm_n <= !raw && (raw == raw_prev) && (dt_cnt == '0);
      end
    end

    assign ctrl_a[g]  = ctrl;
    assign per_a[g]   = period;
    assign cmp_a[g]   = compare;
    assign dead_a[g]  = dead;
    assign cnt_a[g]   = count;
    assign capt_a[g]  = capt;
    assign stat_a[g]  = {capt_flag, killed, run};
    assign pwm_v[g]   = pwm;
    assign pwm_n_v[g] = pwm_n;
  end

  // bits come straight from the per-channel flops
  assign PWM_O   = pwm_v;
  assign PWM_N_O = pwm_n_v;

endmodule : tcpwm_top

//--- common/tcpwm_pkg.sv
package tcpwm_pkg;

  localparam int unsigned CHANNELS = 8;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned DEAD_W   = 8;
  localparam int unsigned DIV_W    = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;

  // channel select and register index fields of the byte address
  localparam int unsigned CH_LSB  = 5;
  localparam int unsigned REG_LSB = 2;

  // register offsets inside one channel window
  localparam logic [2:0] OFF_CTRL    = 3'h0;
  localparam logic [2:0] OFF_PERIOD  = 3'h1;
  localparam logic [2:0] OFF_COMPARE = 3'h2;
  localparam logic [2:0] OFF_DEAD    = 3'h3;
  localparam logic [2:0] OFF_COUNT   = 3'h4;
  localparam logic [2:0] OFF_CAPTURE = 3'h5;
  localparam logic [2:0] OFF_STATUS  = 3'h6;

  // control field positions
  localparam int unsigned CTRL_EN      = 0;
  localparam int unsigned CTRL_ONESHOT = 1;
  localparam int unsigned CTRL_CAP_EN  = 2;
  localparam int unsigned CTRL_KILL_EN = 3;
  localparam int unsigned CTRL_KILL_T  = 4;
  localparam int unsigned CTRL_KILL_C  = 5;
  localparam int unsigned CTRL_PS_LSB  = 8;
  localparam int unsigned CTRL_W       = 11;

  // status field positions
  localparam int unsigned STAT_RUN    = 0;
  localparam int unsigned STAT_KILLED = 1;
  localparam int unsigned STAT_CAPT   = 2;

  // reset values
  localparam logic [CTRL_W-1:0] RST_CTRL    = 11'h000;
  localparam logic [CNT_W-1:0]  RST_PERIOD  = 16'hFFFF;
  localparam logic [CNT_W-1:0]  RST_COMPARE = 16'h0000;
  localparam logic [DEAD_W-1:0] RST_DEAD    = 8'h00;

  // synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;

endpackage : tcpwm_pkg

//--- rtl/tcpwm_sync.sv
`timescale 1ns/1ps
module tcpwm_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  // first stage feeds only the second
  logic [W-1:0] meta;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : tcpwm_sync

//--- tb/tcpwm_asserts.sv
`timescale 1ns/1ps
module tcpwm_asserts
  import tcpwm_pkg::*;
#(
  parameter int unsigned NCH = 8
) (
  input wire logic                         CLK_I,
  input wire logic                         RST_I,
  input wire logic                         PSEL_I,
  input wire logic                         PENABLE_I,
  input wire logic                         PWRITE_I,
  input wire logic [tcpwm_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [tcpwm_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [tcpwm_pkg::DATA_W-1:0] PRDATA_O,
  input wire logic                         PREADY_O,
  input wire logic                         PSLVERR_O,
  input wire logic [NCH-1:0]               CAPTURE_I,
  input wire logic [NCH-1:0]               KILL_I,
  input wire logic [NCH-1:0]               PWM_O,
  input wire logic [NCH-1:0]               PWM_N_O
);
  // kill window: pin plus sync and release lag, dead-band rules off
  logic [NCH-1:0] k1, k2, k3, k4, k5, kz;
  logic [5:0]     ctrl0;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  assign kz = KILL_I | k1 | k2 | k3 | k4 | k5;
  always_ff @(posedge CLK_I) begin
    {k5, k4, k3, k2, k1} <= {k4, k3, k2, k1, KILL_I};
  end
  // shadow of channel 0 control, seen at the completing edge
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl0 <= '0;
    end else if (PSEL_I && PREADY_O && PWRITE_I && PADDR_I == 8'h00) begin
      ctrl0 <= PWDATA_I[5:0];
    end
  end
  sequence s_kill_held;
    (ctrl0[3] && KILL_I[0]) [*3];
  endsequence
  property p_ready; PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O; endproperty
  property p_err;
    PREADY_O |-> PSLVERR_O == (PADDR_I[4:2] == 3'h7 || PADDR_I[1:0] != 2'h0);
  endproperty
  property p_rdata; !PREADY_O |-> PRDATA_O == 32'h0000_0000; endproperty
  property p_excl; (PWM_O & PWM_N_O & ~kz) == '0; endproperty
  property p_gap_n; $fell(PWM_N_O[0]) && !kz[0] |=> !PWM_O[0]; endproperty
  property p_gap_p;
    $rose(PWM_O[0]) && !kz[0] |-> !$past(PWM_N_O[0]);
  endproperty
  property p_kill;
    s_kill_held |=> PWM_O[0] == ctrl0[4] && PWM_N_O[0] == ctrl0[5];
  endproperty
  property p_off; (!ctrl0[0] && !kz[0]) [*3] |-> !PWM_O[0] && !PWM_N_O[0];
  endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after access");
  a_err: assert property (p_err)
    else $error("slave error wrong");
  a_rdata: assert property (p_rdata)
    else $error("read data outside ready");
  a_excl: assert property (p_excl)
    else $error("both outputs on");
  a_gap_n: assert property (p_gap_n)
    else $error("no gap after complement off");
  a_gap_p: assert property (p_gap_p)
    else $error("true on without gap");
  a_kill: assert property (p_kill)
    else $error("kill level not forced");
  a_off: assert property (p_off)
    else $error("outputs on while disabled");
endmodule : tcpwm_asserts

//--- tb/tcpwm_plant.sv
`timescale 1ns/1ps
module tcpwm_plant #(
  parameter int unsigned NCH = 8
) (
  input  wire logic           rst_i,
  input  wire logic [NCH-1:0] pwm_i,
  input  wire logic [NCH-1:0] pwm_n_i,
  input  wire logic [NCH-1:0] cap_req_i,
  input  wire logic [NCH-1:0] kill_req_i,
  output logic      [NCH-1:0] cap_o,
  output logic      [NCH-1:0] kill_o
);
  // event sensor passes straight through
  assign cap_o = cap_req_i;
  // shoot-through of a switch pair trips the overcurrent sense
  assign kill_o = kill_req_i | (rst_i ? '0 : (pwm_i & pwm_n_i));
endmodule : tcpwm_plant

//--- tb/tcpwm_top_tb.sv
`timescale 1ns/1ps
module tcpwm_top_tb;
  import tcpwm_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, pready, pslverr;
  logic        er;
  logic [7:0]  paddr = '0, cap, kill, pwm, pwm_n, cap_req = '0, kill_req = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  int          fails = 0, comparisons = 0;
  initial forever #12.5 clk = ~clk;
  tcpwm_top #(.NCH(8)) tcpwm_top_inst (.CLK_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CAPTURE_I(cap), .KILL_I(kill), .PWM_O(pwm),
    .PWM_N_O(pwm_n));
  tcpwm_plant #(.NCH(8)) tcpwm_plant_inst (.rst_i(rst), .pwm_i(pwm),
    .pwm_n_i(pwm_n), .cap_req_i(cap_req), .kill_req_i(kill_req),
    .cap_o(cap), .kill_o(kill));
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // one wait state expected, but the answer is awaited, not assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    // pready and the answer are taken at the rising edge itself
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    pen <= 0;
  endtask : bus
  task automatic t_reset();
    bus(0, 8'h04, 0);
    chk("period", 32'h0000_FFFF, rd);
    bus(0, 8'h08, 0);
    chk("compare", 32'h0000_0000, rd);
    bus(0, 8'h00, 0);
    chk("ctrl", 32'h0000_0000, rd);
  endtask : t_reset
  task automatic t_unmapped();
    bus(0, 8'h1C, 0);
    chk("err", 32'h0000_0001, {31'h0, er});
    bus(1, 8'h14, 32'h0000_ABCD);
    bus(0, 8'h14, 0);
    chk("capture ro", 32'h0000_0000, rd);
    bus(1, 8'h05, 0);
    chk("misaligned", 32'h0000_0001, {31'h0, er});
  endtask : t_unmapped
  task automatic t_capture();
    bus(1, 8'h50, 32'h0000_1234);
    bus(1, 8'h40, 32'h0000_0004);
    cap_req <= 8'h04;
    repeat (3) @(posedge clk);
    cap_req <= 8'h00;
    repeat (5) @(posedge clk);
    bus(0, 8'h54, 0);
    chk("capture", 32'h0000_1234, rd);
    bus(0, 8'h58, 0);
    chk("cap flag", 32'h0000_0004, rd);
    bus(1, 8'h58, 32'h0000_0004);
    bus(0, 8'h58, 0);
    chk("flag clr", 32'h0000_0000, rd);
    bus(0, 8'h50, 0);
    chk("held", 32'h0000_1234, rd);
  endtask : t_capture
  task automatic t_count();
    logic [31:0] prev;
    bus(1, 8'h24, 32'h0000_0014);
    bus(1, 8'h30, 0);
    bus(1, 8'h20, 32'h0000_0003);
    repeat (60) @(posedge clk);
    bus(0, 8'h30, 0);
    chk("halt", 32'h0000_0014, rd);
    bus(0, 8'h38, 0);
    chk("stopped", 32'h0000_0000, rd);
    bus(1, 8'h24, 32'h0000_0009);
    bus(1, 8'h20, 32'h0000_0001);
    bus(0, 8'h30, 0);
    prev = rd;
    // reads land four cycles apart, period length is ten
    for (int i = 0; i < 6; i++) begin
      bus(0, 8'h30, 0);
      chk("reload", (prev + 4) % 10, rd);
      prev = rd;
    end
  endtask : t_count
  task automatic t_prescale();
    logic [31:0] prev;
    bus(1, 8'h70, 0);
    bus(1, 8'h60, 32'h0000_0201);
    bus(0, 8'h70, 0);
    prev = rd;
    // four cycles between reads hold exactly one tick at prescale two
    for (int i = 0; i < 4; i++) begin
      bus(0, 8'h70, 0);
      chk("prescale", prev + 1, rd);
      prev = rd;
    end
    // capture disabled on this channel, pin edge must be ignored
    cap_req <= 8'h08;
    repeat (3) @(posedge clk);
    cap_req <= 8'h00;
    repeat (5) @(posedge clk);
    bus(0, 8'h74, 0);
    chk("cap refused", 32'h0000_0000, rd);
  endtask : t_prescale
  task automatic t_pwm();
    int hp, hn;
    bus(1, 8'h04, 32'h0000_0063);
    bus(1, 8'h08, 32'h0000_001E);
    bus(1, 8'h0C, 32'h0000_0004);
    bus(1, 8'h00, 32'h0000_0001);
    repeat (250) @(posedge clk);
    hp = 0;
    hn = 0;
    repeat (100) begin
      @(negedge clk);
      hp += pwm[0];
      hn += pwm_n[0];
    end
    chk("true on", 32'd25, hp);
    chk("compl on", 32'd65, hn);
  endtask : t_pwm
  task automatic t_kill();
    int bad;
    bus(1, 8'h00, 32'h0000_0019);
    kill_req <= 8'h01;
    repeat (4) @(posedge clk);
    bad = 0;
    repeat (20) begin
      @(negedge clk);
      bad += (pwm[0] !== 1'b1 || pwm_n[0] !== 1'b0);
    end
    chk("forced", 32'd0, bad);
    bus(0, 8'h18, 0);
    chk("killed", 32'h0000_0003, rd);
    kill_req <= 8'h00;
    repeat (10) @(posedge clk);
    bus(1, 8'h00, 0);
    repeat (10) @(posedge clk);
    chk("off", 32'h0000_0000, {pwm_n[0], pwm[0]});
  endtask : t_kill
  task automatic test_done();
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    t_reset();
    t_unmapped();
    t_capture();
    t_count();
    t_prescale();
    t_pwm();
    t_kill();
    test_done();
  end
endmodule : tcpwm_top_tb
bind tcpwm_top tcpwm_asserts #(.NCH(NCH)) tcpwm_asserts_inst (.CLK_I(CLK_I),
  .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CAPTURE_I(CAPTURE_I),
  .KILL_I(KILL_I), .PWM_O(PWM_O), .PWM_N_O(PWM_N_O));
